// *** rtl/wake_event_control.v ***
// wake event control, status flags, pattern data port and apb slave
// Operation
// - pattern four, five enables at 26, 25
// - link-down enable 17 sets link flag
// - link-up enable 16 sets link flag
// - frame enable 10 raises pm event
// - special packet enable 9 raises pm event
// - link change enable 8 raises pm event
// - wake frame flag at bit 2
// - special packet flag at bit 1
// - link change flag at bit 0
// - flags write-one clear, power-up reset only
// - all pattern data through port 70h
// - pattern one-three enables at 29-27
`timescale 1ns/10ps
`include "wake_defs.vh"
module wake_event_control (
    // clock and resets
    input wire mclk_i,
    input wire srst_i,
    input wire por_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o,
    // events from receive path and phy
    input wire wake_frame_rx_i,
    input wire special_packet_rx_i,
    input wire link_up_i,
    // to power management and matcher
    output reg pm_event_status_o,
    output wire [4:0] pattern_match_en_o,
    output wire irq_o
);
    // register state
    reg [31:0] ctrl_reg;
    reg [31:0] ctrl_next;
    reg [2:0] flags_reg;
    reg [2:0] flags_next;
    reg [4:0] ptr_reg;
    reg [4:0] ptr_next;
    reg link_reg;
    reg link_next;
    reg link_valid_reg;
    reg link_valid_next;
    reg [2:0] irq_stat_reg;
    reg [2:0] irq_stat_next;
    reg [2:0] irq_mask_reg;
    reg [2:0] irq_mask_next;
    reg rd_phase_reg;
    reg rd_phase_next;
    reg pm_next;
    reg [31:0] prdata_next;

    // bus decode
    wire acc;
    wire wr_acc;
    wire rd_acc;
    wire hit_ctrl;
    wire hit_pdata;
    wire hit_pptr;
    wire hit_istat;
    wire hit_imask;
    wire hit_link;
    wire data_acc;
    wire data_wr;

    // event path
    wire link_rise;
    wire link_fall;
    wire link_event;
    wire frame_event;
    wire packet_event;
    wire [2:0] events;
    wire [2:0] flags_w1c;
    wire [2:0] irq_w1c;

    // memory side
    wire [31:0] mem_rd_data;

    // address compare, shared by the hit decodes and addr_known; the read mux decodes with a case
    function addr_is;
        input [7:0] a;
        input [7:0] target;
        begin
            addr_is = (a == target);
        end
    endfunction

    // any mapped register; everything else answers with an error
    function addr_known;
        input [7:0] a;
        begin
            addr_known = addr_is(a, `WK_CTRL_ADDR) || addr_is(a, `WK_PDATA_ADDR) ||
                addr_is(a, `WK_PPTR_ADDR) || addr_is(a, `WK_IRQ_STAT_ADDR) ||
                addr_is(a, `WK_IRQ_MASK_ADDR) || addr_is(a, `WK_LINK_ADDR);
        end
    endfunction

    // pointer step: wraps after the last word of pattern six
    function [4:0] ptr_inc;
        input [4:0] p;
        begin
            ptr_inc = (p == `WK_PTR_LAST) ? 5'h00 : p + 5'h01;
        end
    endfunction

    // pointer load: out-of-range values fall back to word zero
    function [4:0] ptr_clip;
        input [4:0] p;
        begin
            ptr_clip = (p > `WK_PTR_LAST) ? 5'h00 : p;
        end
    endfunction

    // write-one-clear: set wins when event and clear meet
    function [2:0] w1c_update;
        input [2:0] cur;
        input [2:0] clr;
        input [2:0] set;
        begin
            w1c_update = (cur & ~clr) | set;
        end
    endfunction

    // control write keeps reserved bits at their fixed value
    function [31:0] ctrl_merge;
        input [31:0] wd;
        begin
            ctrl_merge = (wd & `WK_CTRL_RW_MASK) | `WK_RSVD_15_11;
        end
    endfunction

    assign acc = psel_i && penable_i;
    assign wr_acc = acc && pwrite_i;
    assign rd_acc = acc && !pwrite_i;
    assign hit_ctrl = addr_is(paddr_i, `WK_CTRL_ADDR);
    assign hit_pdata = addr_is(paddr_i, `WK_PDATA_ADDR);
    assign hit_pptr = addr_is(paddr_i, `WK_PPTR_ADDR);
    assign hit_istat = addr_is(paddr_i, `WK_IRQ_STAT_ADDR);
    assign hit_imask = addr_is(paddr_i, `WK_IRQ_MASK_ADDR);
    assign hit_link = addr_is(paddr_i, `WK_LINK_ADDR);

    // data port reads wait one cycle for the registered memory output
    assign pready_o = !(rd_acc && hit_pdata) || rd_phase_reg;
    assign pslverr_o = acc && !addr_known(paddr_i);
    assign data_acc = acc && pready_o && hit_pdata;
    assign data_wr = data_acc && pwrite_i;
    assign flags_w1c = (wr_acc && hit_ctrl) ? pwdata_i[2:0] : 3'h0;
    assign irq_w1c = (wr_acc && hit_istat) ? pwdata_i[2:0] : 3'h0;

    // a freshly reset sampler would fake an edge, so wait one sample
    assign link_rise = link_valid_reg && link_up_i && !link_reg;
    assign link_fall = link_valid_reg && !link_up_i && link_reg;
    assign link_event = (link_fall && ctrl_reg[`WK_LDOWN_EN]) ||
        (link_rise && ctrl_reg[`WK_LUP_EN]);
    assign frame_event = wake_frame_rx_i;
    assign packet_event = special_packet_rx_i;
    assign events = {frame_event, packet_event, link_event};

    assign pattern_match_en_o = {ctrl_reg[`WK_P1_EN], ctrl_reg[`WK_P2_EN],
        ctrl_reg[`WK_P3_EN], ctrl_reg[`WK_P4_EN], ctrl_reg[`WK_P5_EN]};
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    always @* begin
        ctrl_next = ctrl_reg;
        if (wr_acc && hit_ctrl) begin
            ctrl_next = ctrl_merge(pwdata_i);
        end
    end

    always @* begin
        irq_mask_next = irq_mask_reg;
        if (wr_acc && hit_imask) begin
            irq_mask_next = pwdata_i[2:0];
        end
    end

    always @* begin
        link_next = link_up_i;
        link_valid_next = 1'b1;
    end

    always @* begin
        rd_phase_next = 1'b0;
        if (rd_acc && hit_pdata && !rd_phase_reg) begin
            rd_phase_next = 1'b1;
        end
    end

    // pm output is registered: one pulse per cycle with any enabled event
    always @* begin
        pm_next = 1'b0;
        if (frame_event && ctrl_reg[`WK_FRAME_EV_EN]) begin
            pm_next = 1'b1;
        end
        if (packet_event && ctrl_reg[`WK_SPKT_EV_EN]) begin
            pm_next = 1'b1;
        end
        if (link_event && ctrl_reg[`WK_LCHG_EV_EN]) begin
            pm_next = 1'b1;
        end
    end

    // flags are set irrespective of the event enables
    always @* begin
        flags_next = w1c_update(flags_reg, flags_w1c, 3'h0);
        if (frame_event) begin
            flags_next[`WK_FRAME_SEEN] = 1'b1;
        end
        if (packet_event) begin
            flags_next[`WK_SPKT_SEEN] = 1'b1;
        end
        if (link_event) begin
            flags_next[`WK_LCHG_SEEN] = 1'b1;
        end
    end

    always @* begin
        irq_stat_next = w1c_update(irq_stat_reg, irq_w1c, events);
    end

    // word pointer: 5 words per pattern, mask words first
    always @* begin
        ptr_next = ptr_reg;
        if (wr_acc && hit_pptr) begin
            ptr_next = ptr_clip(pwdata_i[4:0]);
        end else if (data_acc) begin
            ptr_next = ptr_inc(ptr_reg);
        end
    end

    // read data: reloaded each read cycle, settled by the completing edge
    always @* begin
        prdata_next = prdata_o;
        if (psel_i && !pwrite_i) begin
            case (paddr_i)
                `WK_CTRL_ADDR: begin
                    prdata_next = ctrl_reg | {29'h0, flags_reg};
                end
                `WK_PDATA_ADDR: begin
                    prdata_next = mem_rd_data;
                end
                `WK_PPTR_ADDR: begin
                    prdata_next = {27'h0, ptr_reg};
                end
                `WK_IRQ_STAT_ADDR: begin
                    prdata_next = {29'h0, irq_stat_reg};
                end
                `WK_IRQ_MASK_ADDR: begin
                    prdata_next = {29'h0, irq_mask_reg};
                end
                `WK_LINK_ADDR: begin
                    prdata_next = {31'h0, link_reg};
                end
                default: begin
                    prdata_next = 32'h00000000;
                end
            endcase
        end
    end

    // soft reset domain: control, mask and pointer
    always @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_reg <= `WK_RSVD_15_11;
            irq_mask_reg <= 3'h0;
            ptr_reg <= 5'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            irq_mask_reg <= irq_mask_next;
            ptr_reg <= ptr_next;
        end
    end

    // link sampler and bus phase
    always @(posedge mclk_i) begin
        if (srst_i) begin
            link_reg <= 1'b0;
            link_valid_reg <= 1'b0;
            rd_phase_reg <= 1'b0;
        end else begin
            link_reg <= link_next;
            link_valid_reg <= link_valid_next;
            rd_phase_reg <= rd_phase_next;
        end
    end

    // registered outputs
    always @(posedge mclk_i) begin
        if (srst_i) begin
            pm_event_status_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pm_event_status_o <= pm_next;
            prdata_o <= prdata_next;
        end
    end

    // flags survive the soft reset, only power-up clears them
    always @(posedge mclk_i) begin
        if (por_i) begin
            flags_reg <= 3'h0;
            irq_stat_reg <= 3'h0;
        end else begin
            flags_reg <= flags_next;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // contents kept across soft reset; software reprograms after power-up
    wake_pattern_mem u_mem (
        .mclk_i(mclk_i),
        .wr_en_i(data_wr),
        .wr_addr_i(ptr_reg),
        .wr_data_i(pwdata_i),
        .rd_addr_i(ptr_reg),
        .rd_data_o(mem_rd_data)
    );

    // link level readback for software polling
    // unmapped accesses answer at once with an error and no effect
endmodule

// *** common/wake_defs.vh ***
// register offsets, field positions and reset values of the wake event block
`ifndef WAKE_DEFS_VH
`define WAKE_DEFS_VH
`define WK_CTRL_ADDR 8'h68
`define WK_PDATA_ADDR 8'h70
`define WK_PPTR_ADDR 8'h74
`define WK_IRQ_STAT_ADDR 8'h78
`define WK_IRQ_MASK_ADDR 8'h7C
`define WK_LINK_ADDR 8'h80
`define WK_P1_EN 29
`define WK_P2_EN 28
`define WK_P3_EN 27
`define WK_P4_EN 26
`define WK_P5_EN 25
`define WK_LDOWN_EN 17
`define WK_LUP_EN 16
`define WK_FRAME_EV_EN 10
`define WK_SPKT_EV_EN 9
`define WK_LCHG_EV_EN 8
`define WK_FRAME_SEEN 2
`define WK_SPKT_SEEN 1
`define WK_LCHG_SEEN 0
`define WK_CTRL_RW_MASK 32'h3E030700
`define WK_RSVD_15_11 32'h00000800
`define WK_FLAGS_MASK 32'h00000007
`define WK_WORDS_PER_PAT 5
`define WK_PATTERNS 6
`define WK_MEM_WORDS 30
`define WK_PTR_LAST 5'h1D
`endif

// *** rtl/wake_pattern_mem.v ***
// pattern filter storage: 30 words, registered read data
`timescale 1ns/10ps
module wake_pattern_mem (
    // clock
    input wire mclk_i,
    // write port
    input wire wr_en_i,
    input wire [4:0] wr_addr_i,
    input wire [31:0] wr_data_i,
    // read port
    input wire [4:0] rd_addr_i,
    output reg [31:0] rd_data_o
);
    reg [31:0] mem [0:29];

    // contents are not reset: software must program before enabling matches
    always @(posedge mclk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// *** verification/wake_event_chk.sv ***
// port assertions for the wake event block
`timescale 1ns/10ps
`include "wake_defs.vh"
module wake_event_chk (
    input wire mclk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire wake_frame_rx_i, special_packet_rx_i, link_up_i, pm_event_status_o,
    input wire [4:0] pattern_match_en_o
);
    reg [31:0] c;
    reg lp;
    // shadow of control, the checker sees no registers
    wire up = link_up_i & ~lp & c[16];
    wire dn = ~link_up_i & lp & c[17];
    always @(posedge mclk_i) begin
        lp <= link_up_i;
        if (srst_i)
            c <= 32'h00000800;
        else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `WK_CTRL_ADDR)
            c <= pwdata_i;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_fr; wake_frame_rx_i && c[10] |=> pm_event_status_o; endproperty
    a_fr: assert property (p_fr) else $error("no pm after frame");
    property p_sp; special_packet_rx_i && c[9] |=> pm_event_status_o; endproperty
    a_sp: assert property (p_sp) else $error("no pm after packet");
    property p_up; up && c[8] |=> pm_event_status_o; endproperty
    a_up: assert property (p_up) else $error("no pm after link up");
    property p_dn; dn && c[8] |=> pm_event_status_o; endproperty
    a_dn: assert property (p_dn) else $error("no pm after link down");
    property p_lc; (up || dn) && !c[8] && !wake_frame_rx_i && !special_packet_rx_i
        |=> !pm_event_status_o; endproperty
    a_lc: assert property (p_lc) else $error("pm from disabled link");
    property p_pm; pm_event_status_o |-> $past(wake_frame_rx_i && c[10] ||
        special_packet_rx_i && c[9] || (up || dn) && c[8]); endproperty
    a_pm: assert property (p_pm) else $error("pm without event");
    property p_p45; pattern_match_en_o[1:0] == c[26:25]; endproperty
    a_p45: assert property (p_p45) else $error("pattern 4-5 enable");
    property p_p13; pattern_match_en_o[4:2] == c[29:27]; endproperty
    a_p13: assert property (p_p13) else $error("pattern 1-3 enable");
    c_fr: cover property (wake_frame_rx_i && c[10]);
    c_ln: cover property (up || dn);
    c_rd: cover property (psel_i && penable_i && pready_o && paddr_i == `WK_PDATA_ADDR);
endmodule
bind wake_event_control wake_event_chk i_chk (.*);

// *** verification/link_model.sv ***
// network side: link level and received wake traffic
`timescale 1ns/10ps
module link_model (
    input wire mclk_i,
    output reg link_up_o,
    output reg frame_o,
    output reg packet_o
);
    initial {link_up_o, frame_o, packet_o} = 3'h0;
    // 0 frame, 1 packet, else toggle link; pulses last one cycle
    task pulse(input integer k);
        begin
            @(posedge mclk_i);
            if (k == 0) frame_o <= 1'b1;
            else if (k == 1) packet_o <= 1'b1;
            else link_up_o <= ~link_up_o;
            @(posedge mclk_i);
            frame_o <= 1'b0;
            packet_o <= 1'b0;
        end
    endtask
endmodule

// *** verification/tb_wake_event_control.sv ***
// self-checking bench for the wake event block
`timescale 1ns/10ps
module tb_wake_event_control;
    reg mclk_i = 1'b0, srst_i = 1'b1, por_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    reg pwrite_i = 1'b0;
    reg [7:0] paddr_i = 8'h00;
    reg [31:0] pwdata_i = 32'h0, d;
    wire pready_o, pslverr_o, pm_event_status_o, irq_o;
    wire link_up_i, wake_frame_rx_i, special_packet_rx_i;
    wire [31:0] prdata_o;
    wire [4:0] pattern_match_en_o;
    integer fail_count = 0, n_checks = 0, i, err;
    wake_event_control i_dut (.*);
    link_model i_link (.mclk_i(mclk_i), .link_up_o(link_up_i), .frame_o(wake_frame_rx_i),
        .packet_o(special_packet_rx_i));
    initial forever #5 mclk_i = ~mclk_i;
    task print_verdict; begin
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    end endtask
    task chk(input string nm, input [31:0] e, input [31:0] g); begin
        n_checks = n_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, g);
        end
    end endtask
    // data port reads add a wait state, so never assume a count
    task apb(input w, input [7:0] a, input [31:0] wd); integer t; begin
        @(posedge mclk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, wd};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        t = 0;
        do begin @(posedge mclk_i); t = t + 1; end while (pready_o !== 1'b1 && t < 50);
        d = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'h0;
        if (t == 50) begin fail_count = fail_count + 1; print_verdict; end
    end endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        {srst_i, por_i} <= 2'h0;
        apb(0, 8'h68, 0);
        chk("ctrl", 32'h00000800, d);
        apb(1, 8'h68, 32'hFFFFFFFF);
        apb(0, 8'h68, 0);
        chk("ctrl", 32'h3E030F00, d);
        chk("en", 32'h1F, pattern_match_en_o);
        $display("test enables done");
        for (i = 0; i < 4; i = i + 1) begin
            i_link.pulse(i > 2 ? 2 : i);
            @(negedge mclk_i);
            chk("pm", 1, pm_event_status_o);
            apb(0, 8'h68, 0);
            chk("flag", 32'h3E030F00 | (4 >> (i > 2 ? 2 : i)), d);
            apb(1, 8'h68, d);
            apb(0, 8'h68, 0);
            chk("clear", 32'h3E030F00, d);
        end
        $display("test events done");
        apb(1, 8'h7C, 7);
        apb(1, 8'h78, 7);
        @(negedge mclk_i);
        chk("irq", 0, irq_o);
        i_link.pulse(1);
        @(negedge mclk_i);
        chk("irq", 1, irq_o);
        apb(1, 8'h78, 2);
        @(negedge mclk_i);
        chk("irq", 0, irq_o);
        i_link.pulse(0);
        srst_i <= 1'b1;
        @(posedge mclk_i);
        srst_i <= 1'b0;
        apb(0, 8'h68, 0);
        chk("keep", 32'h00000806, d);
        apb(1, 8'h68, 32'h00010007);
        i_link.pulse(2);
        @(negedge mclk_i);
        chk("pm off", 0, pm_event_status_o);
        apb(0, 8'h68, 0);
        chk("up only", 32'h00010801, d);
        $display("test reset done");
        apb(1, 8'h74, 0);
        for (i = 0; i < 5; i = i + 1) apb(1, 8'h70, 32'hA5C30000 + i);
        apb(0, 8'h74, 0);
        chk("ptr", 5, d);
        apb(1, 8'h74, 0);
        for (i = 0; i < 5; i = i + 1) begin
            apb(0, 8'h70, 0);
            chk("word", 32'hA5C30000 + i, d);
        end
        apb(1, 8'h74, 29);
        apb(1, 8'h70, 0);
        apb(0, 8'h74, 0);
        chk("wrap", 0, d);
        apb(0, 8'h00, 0);
        chk("err", 1, err);
        $display("test data port done");
        print_verdict;
    end
endmodule
